// ==== verilog/watchdog_timer_control.sv ====
`timescale 1ns/10ps

// How it works
// - Prescale code picks timeout 15.6 to 2000 ms.
// - Action-select bit makes timeout a priority interrupt.
// - Status flag set on timeout; survives watchdog reset.
// - Missed refresh resets or interrupts per select bit.
// - Control write accepted only right after unlock.
// - Timer mode uses prescale as interrupt period.
// - 16-bit counter at 32.768 kHz; reset 10H.
module watchdog_timer_control (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       supply_monitor_irq,
	output logic      [7:0] watchdog_control,
	output logic            wd_reset_req,
	output logic            wd_irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [3:0]  timeout_code;
	logic        timeout_action_select;
	logic        timeout_occurred_flag;
	logic        watchdog_refresh_enable;
	logic        control_write_unlock;
	logic [15:0] count;
	logic [25:0] phase;
	logic        tick;
	logic [3:0]  next_timeout_code;
	logic        next_timeout_action_select;
	logic        next_timeout_occurred_flag;
	logic        next_watchdog_refresh_enable;
	logic        next_control_write_unlock;
	logic [15:0] next_count;
	logic [25:0] next_phase;
	logic        next_tick;
	logic        next_wd_reset_req;
	logic        next_wd_irq;
	logic [15:0] limit;
	logic        expire;
	logic        immediate;
	logic        accept;

	// ----------------------------------------
	// Slow time base
	// ----------------------------------------
	// A phase accumulator gives the exact average tick rate without a second clock.
	always_comb begin
		if (phase + watchdog_pkg::PHASE_STEP >= watchdog_pkg::PHASE_WRAP) begin
			next_phase = phase + watchdog_pkg::PHASE_STEP - watchdog_pkg::PHASE_WRAP;
			next_tick  = 1'b1;
		end else begin
			next_phase = phase + watchdog_pkg::PHASE_STEP;
			next_tick  = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase <= 26'h0000000;
			tick  <= 1'b0;
		end else begin
			phase <= next_phase;
			tick  <= next_tick;
		end
	end

	// ----------------------------------------
	// Control and counter
	// ----------------------------------------
	assign limit     = 16'((watchdog_pkg::BASE_TICKS << timeout_code[2:0]) - 17'h00001);
	assign expire    = watchdog_refresh_enable && tick && count == limit
	                   && timeout_code <= watchdog_pkg::CODE_LONGEST;
	assign immediate = watchdog_refresh_enable && timeout_code == watchdog_pkg::CODE_IMMEDIATE;
	assign accept    = sfr_wr && control_write_unlock;

	always_comb begin
		next_timeout_code            = timeout_code;
		next_timeout_action_select   = timeout_action_select;
		next_timeout_occurred_flag   = timeout_occurred_flag;
		next_watchdog_refresh_enable = watchdog_refresh_enable;
		next_control_write_unlock    = control_write_unlock;
		next_count                   = count;
		next_wd_reset_req            = 1'b0;
		next_wd_irq                  = 1'b0;
		if (sfr_wr) begin
			// Any write after the unlock consumes it; the unlock write itself stores nothing.
			next_control_write_unlock = control_write_unlock ? 1'b0 :
			                            sfr_wdata[watchdog_pkg::UNLOCK_BIT];
		end
		if (accept) begin
			next_timeout_code            = sfr_wdata[watchdog_pkg::CODE_HI:watchdog_pkg::CODE_LO];
			next_timeout_action_select   = sfr_wdata[watchdog_pkg::ACTION_BIT];
			next_timeout_occurred_flag   = sfr_wdata[watchdog_pkg::FLAG_BIT];
			next_watchdog_refresh_enable = sfr_wdata[watchdog_pkg::REFRESH_BIT];
			next_count                   = 16'h0000;
		end else if (!watchdog_refresh_enable) begin
			next_count = 16'h0000;
		end else if (expire) begin
			next_count = 16'h0000;
		end else if (tick) begin
			next_count = count + 16'h0001;
		end
		if (supply_monitor_irq) begin
			next_watchdog_refresh_enable = 1'b0;
		end
		if (expire && timeout_action_select) begin
			next_wd_irq                = 1'b1;
			next_timeout_occurred_flag = 1'b1;
		end else if ((expire && !timeout_action_select) || immediate) begin
			// A watchdog reset restores the power-on layout but sets the status flag.
			next_timeout_code            = watchdog_pkg::CONTROL_RESET[watchdog_pkg::CODE_HI:
			                                                           watchdog_pkg::CODE_LO];
			next_timeout_action_select   = 1'b0;
			next_watchdog_refresh_enable = 1'b0;
			next_control_write_unlock    = 1'b0;
			next_timeout_occurred_flag   = 1'b1;
			next_count                   = 16'h0000;
			next_wd_reset_req            = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			timeout_code            <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::CODE_HI:
			                                                      watchdog_pkg::CODE_LO];
			timeout_action_select   <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::ACTION_BIT];
			timeout_occurred_flag   <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::FLAG_BIT];
			watchdog_refresh_enable <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::REFRESH_BIT];
			control_write_unlock    <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::UNLOCK_BIT];
			count                   <= 16'h0000;
			wd_reset_req            <= 1'b0;
			wd_irq                  <= 1'b0;
		end else begin
			timeout_code            <= next_timeout_code;
			timeout_action_select   <= next_timeout_action_select;
			timeout_occurred_flag   <= next_timeout_occurred_flag;
			watchdog_refresh_enable <= next_watchdog_refresh_enable;
			control_write_unlock    <= next_control_write_unlock;
			count                   <= next_count;
			wd_reset_req            <= next_wd_reset_req;
			wd_irq                  <= next_wd_irq;
		end
	end

	assign watchdog_control = {timeout_code, timeout_action_select, timeout_occurred_flag,
	                           watchdog_refresh_enable, control_write_unlock};

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_expire_acts;
		@(posedge clk) disable iff (!rstn)
		expire |=> (wd_irq || wd_reset_req);
	endproperty
	a_expire_acts: assert property (p_expire_acts) else $error("Expiry did not act.");

	property p_irq_mode;
		@(posedge clk) disable iff (!rstn)
		(expire && timeout_action_select) |=> (wd_irq && !wd_reset_req
		&& (watchdog_refresh_enable || $past(supply_monitor_irq) || $past(accept)));
	endproperty
	a_irq_mode: assert property (p_irq_mode) else $error("Timer mode did not interrupt.");

	property p_flag_on_reset;
		@(posedge clk) disable iff (!rstn)
		wd_reset_req |-> timeout_occurred_flag ##1 timeout_occurred_flag;
	endproperty
	a_flag_on_reset: assert property (p_flag_on_reset) else $error("Status flag lost.");

	property p_reset_mode;
		@(posedge clk) disable iff (!rstn)
		(expire && !timeout_action_select) |=> (wd_reset_req && !watchdog_refresh_enable);
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("Missed refresh did not reset.");

	property p_supply_clear;
		@(posedge clk) disable iff (!rstn)
		supply_monitor_irq |=> !watchdog_refresh_enable;
	endproperty
	a_supply_clear: assert property (p_supply_clear) else $error("Enable not cleared.");

	property p_locked;
		@(posedge clk) disable iff (!rstn)
		(sfr_wr && !control_write_unlock && !expire && !immediate)
		|=> $stable(timeout_code) && $stable(timeout_action_select);
	endproperty
	a_locked: assert property (p_locked) else $error("Locked write changed control.");

	property p_period;
		@(posedge clk) disable iff (!rstn)
		wd_irq |-> $past(count) == $past(limit);
	endproperty
	a_period: assert property (p_period) else $error("Interrupt at wrong count.");

	property p_tick_rate;
		@(posedge clk) disable iff (!rstn)
		tick |=> !tick [*8];
	endproperty
	a_tick_rate: assert property (p_tick_rate) else $error("Time base too fast.");

	property p_immediate;
		@(posedge clk) disable iff (!rstn)
		immediate |=> (wd_reset_req && timeout_occurred_flag && !watchdog_refresh_enable);
	endproperty
	a_immediate: assert property (p_immediate) else $error("No immediate reset.");

	property p_accept_store;
		@(posedge clk) disable iff (!rstn)
		(accept && !expire && !immediate)
		|=> timeout_code == $past(sfr_wdata[watchdog_pkg::CODE_HI:watchdog_pkg::CODE_LO]);
	endproperty
	a_accept_store: assert property (p_accept_store) else $error("Write lost.");

	property p_disabled_hold;
		@(posedge clk) disable iff (!rstn)
		!watchdog_refresh_enable |=> count == 16'h0000;
	endproperty
	a_disabled_hold: assert property (p_disabled_hold) else $error("Count not held.");

	c_irq:       cover property (@(posedge clk) disable iff (!rstn) wd_irq);
	c_reset:     cover property (@(posedge clk) disable iff (!rstn) wd_reset_req);
	c_immediate: cover property (@(posedge clk) disable iff (!rstn) immediate);
	c_unlocked:  cover property (@(posedge clk) disable iff (!rstn) accept);

endmodule // watchdog_timer_control

// ==== pkg/watchdog_pkg.sv ====
package watchdog_pkg;

	// ----------------------------------------
	// Control register layout
	// ----------------------------------------
	localparam int         CODE_HI     = 7;
	localparam int         CODE_LO     = 4;
	localparam int         ACTION_BIT  = 3;
	localparam int         FLAG_BIT    = 2;
	localparam int         REFRESH_BIT = 1;
	localparam int         UNLOCK_BIT  = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h10;

	// ----------------------------------------
	// Timeout codes and timing
	// ----------------------------------------
	localparam logic [3:0]  CODE_LONGEST   = 4'h7;
	localparam logic [3:0]  CODE_IMMEDIATE = 4'h8;
	localparam int          CLK_HZ         = 40000000;
	localparam int          WDT_HZ         = 32768;
	localparam int          BASE_SHIFT     = 9;
	localparam logic [16:0] BASE_TICKS     = 17'(2 ** BASE_SHIFT);
	localparam logic [25:0] PHASE_STEP     = 26'(WDT_HZ);
	localparam logic [25:0] PHASE_WRAP     = 26'(CLK_HZ);

endpackage

// ==== testbench/watchdog_timer_control_test.sv ====
`timescale 1ns/10ps

module watchdog_timer_control_test;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic       clk;
	logic       rstn;
	logic       sfr_wr;
	logic [7:0] sfr_wdata;
	logic       supply_monitor_irq;
	logic [7:0] watchdog_control;
	logic       wd_reset_req;
	logic       wd_irq;
	int         failures;
	int         checks_done;
	int         n_rst;
	int         n_irq;

	watchdog_timer_control i_dut (
		.clk                (clk),
		.rstn               (rstn),
		.sfr_wr             (sfr_wr),
		.sfr_wdata          (sfr_wdata),
		.supply_monitor_irq (supply_monitor_irq),
		.watchdog_control   (watchdog_control),
		.wd_reset_req       (wd_reset_req),
		.wd_irq             (wd_irq)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] d);
		@(posedge clk);
		sfr_wr    <= 1'b1;
		sfr_wdata <= d;
		@(posedge clk);
		sfr_wr <= 1'b0;
		#1;
	endtask

	// The unlock must be the write just before, so nothing else may slip between.
	task automatic unlocked_wr(input logic [7:0] d);
		wr(8'h01);
		wr(d);
	endtask

	// Pulses are one cycle wide, so every cycle of the window is sampled.
	task automatic count_pulses();
		n_rst = 0;
		n_irq = 0;
		repeat (12) begin
			@(posedge clk);
			#1;
			n_rst += (wd_reset_req === 1'b1) ? 1 : 0;
			n_irq += (wd_irq === 1'b1) ? 1 : 0;
		end
	endtask

	task automatic end_sim();
		$display("checks_done %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		rstn               = 1'b0;
		sfr_wr             = 1'b0;
		sfr_wdata          = 8'h00;
		supply_monitor_irq = 1'b0;
		failures           = 0;
		checks_done        = 0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		#1;
		chk("reset value", watchdog_control, 8'h10);
		wr(8'h72);
		chk("locked write", watchdog_control, 8'h10);
		wr(8'h01);
		chk("unlock armed", watchdog_control, 8'h11);
		wr(8'h72);
		chk("unlocked write", watchdog_control, 8'h72);
		wr(8'h36);
		chk("relocked write", watchdog_control, 8'h72);
		@(posedge clk);
		supply_monitor_irq <= 1'b1;
		@(posedge clk);
		supply_monitor_irq <= 1'b0;
		#1;
		chk("supply clear", watchdog_control, 8'h70);
		unlocked_wr(8'h32);
		chk("refresh", watchdog_control, 8'h32);
		// The slow time base ticks every 1220 or 1221 cycles, so 2500 cycles hold 2 or 3.
		repeat (2500) @(posedge clk);
		#1;
		chk("count runs", 8'(i_dut.count >= 16'h0002 && i_dut.count <= 16'h0003), 8'h01);
		unlocked_wr(8'h32);
		chk("refresh restart", 8'(i_dut.count != 16'h0000), 8'h00);
		unlocked_wr(8'h30);
		chk("user disable", watchdog_control, 8'h30);
		repeat (2500) @(posedge clk);
		#1;
		chk("count held", 8'(i_dut.count != 16'h0000), 8'h00);
		unlocked_wr(8'h80);
		count_pulses();
		chk("disabled code 8 reset", 8'(n_rst), 8'h00);
		chk("disabled code 8 ctrl", watchdog_control, 8'h80);
		unlocked_wr(8'h82);
		count_pulses();
		chk("immediate reset", 8'(n_rst), 8'h01);
		chk("no interrupt", 8'(n_irq), 8'h00);
		chk("after wd reset", watchdog_control, 8'h14);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1;
		chk("after hw reset", watchdog_control, 8'h10);
		end_sim();
	end

endmodule // watchdog_timer_control_test
